/* shared/ccs_pkg.sv */
package ccs_pkg;
   // ==================================================
   // widths and command codes
   localparam int DATA_W = 8;
   localparam int SETUP_W = 16;
   localparam int SLOT_W = 3;
   localparam int ID_W = 4;
   localparam int ROM_AW = 8;

   typedef enum logic [4:0] {
      CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_IDN_Q, CMD_OPC, CMD_OPC_Q, CMD_OPT_Q,
      CMD_RCL, CMD_RST, CMD_SAV, CMD_SRE, CMD_SRE_Q, CMD_STB_Q, CMD_TRG, CMD_TST_Q, CMD_WAI
   } ccs_cmd_e;

   typedef struct packed {
      ccs_cmd_e op;
      logic [DATA_W-1:0] arg;
   } ccs_req_s;

   typedef enum logic [1:0] {
      RSP_BYTE, RSP_ID, RSP_OPT, RSP_TEST
   } ccs_rsp_kind_e;

   typedef struct packed {
      ccs_rsp_kind_e kind;
      logic [DATA_W-1:0] data;
   } ccs_rsp_s;

   // ==================================================
   // bit positions and constants
   localparam int ESR_OPC_BIT = 0;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_EAV_BIT = 2;
   localparam logic [DATA_W-1:0] ASCII_ONE = 8'h31;
   localparam logic [DATA_W-1:0] TST_PASS = 8'h00;
   localparam logic [DATA_W-1:0] TST_FAIL = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [SETUP_W-1:0] SETUP_RST = 16'h0000;
   localparam logic [DATA_W-1:0] ROM_SUM_GOOD = 8'h00;
   localparam logic [ROM_AW-1:0] ROM_LAST = 8'hff;
   localparam logic [ROM_AW-1:0] ROM_FIRST = 8'h00;
endpackage

/* core/ccs_core.sv */
`timescale 1ns/1ps
// What this block does
// RULE1: clear-status clears every event register and empties the error queue.
// RULE2: event-enable loads enable register; its query returns it unchanged.
// RULE3: event status query returns the event register then clears it.
// RULE4: operation-complete sets its event bit only after all pending commands finish.
// RULE5: operation-complete query answers ASCII 1 once pending operations are done.
// RULE6: identification query returns maker, model, serial and firmware revision.
// RULE7: option query reports fitted memory option and scanner card presence.
// RULE8: save stores present setup into the selected memory slot.
// RULE9: recall restores the setup stored in the selected memory slot.
// RULE10: reset returns settings to defaults; status and trace settings unaffected.
// RULE11: service-request-enable loads its register; its query returns it.
// RULE12: status byte query returns the current status byte.
// RULE13: trigger command raises the same bus trigger as group execute.
// RULE14: self-test sums the program ROM and reports pass or fail.
// RULE15: wait-to-continue stalls later commands until earlier ones complete.
// RULE16: status byte summary bit set when any enabled event bit is set.
module ccs_core #(
   parameter logic [ccs_pkg::ID_W-1:0] MAKER_ID = 4'h1, // arbitrary value
   parameter logic [ccs_pkg::ID_W-1:0] MODEL_ID = 4'h2, // arbitrary value
   parameter logic [ccs_pkg::ID_W-1:0] SERIAL_ID = 4'h3, // arbitrary value
   parameter logic [ccs_pkg::ID_W-1:0] FW_REV = 4'h4, // arbitrary value
   parameter int SLOTS = 8
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic req_valid_in,
   input wire ccs_pkg::ccs_req_s req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output ccs_pkg::ccs_rsp_s rsp_out,
   output logic [4*ccs_pkg::ID_W-1:0] idn_out,
   input wire logic pending_busy_in,
   input wire logic [ccs_pkg::DATA_W-1:0] event_set_in,
   input wire logic err_push_in,
   output logic err_clear_out,
   output logic err_avail_out,
   input wire logic [1:0] mem_opt_in,
   input wire logic scanner_in,
   output logic [ccs_pkg::ROM_AW-1:0] rom_addr_out,
   input wire logic [ccs_pkg::DATA_W-1:0] rom_data_in,
   input wire logic [ccs_pkg::SETUP_W-1:0] setup_in,
   output logic [ccs_pkg::SETUP_W-1:0] setup_out,
   output logic setup_load_out,
   output logic bus_trigger_out,
   output logic [ccs_pkg::DATA_W-1:0] stb_out
);
   import ccs_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TEST} ccs_state_e;

   // ==================================================
   // state
   ccs_state_e state_q;
   ccs_cmd_e wait_op_q;
   logic [DATA_W-1:0] ese_q, esr_q, sre_q, rom_sum_q;
   logic [ROM_AW-1:0] rom_addr_q;
   logic [SETUP_W-1:0] slot_q [SLOTS];
   logic [SETUP_W-1:0] setup_q;
   logic err_cnt_nz_q;
   logic take, esr_read, opc_hit;
   logic [SLOT_W-1:0] slot_idx;

   assign req_ready_out = (state_q == ST_IDLE);
   assign take = req_valid_in && req_ready_out;
   assign slot_idx = req_in.arg[SLOT_W-1:0];
   assign esr_read = take && req_in.op == CMD_ESR_Q;
   assign opc_hit = state_q == ST_WAIT && !pending_busy_in && wait_op_q == CMD_OPC; // [RULE4]
   assign idn_out = {MAKER_ID, MODEL_ID, SERIAL_ID, FW_REV}; // [RULE6]
   assign rom_addr_out = rom_addr_q;
   assign setup_out = setup_q;
   assign err_avail_out = err_cnt_nz_q;

   // ==================================================
   // sequencing: opc/wai wait on pending work, tst walks rom
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_q <= ST_IDLE;
         wait_op_q <= CMD_WAI;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take && (req_in.op == CMD_OPC || req_in.op == CMD_OPC_Q || req_in.op == CMD_WAI)) begin
                  state_q <= ST_WAIT; // [RULE15]
                  wait_op_q <= req_in.op;
               end else if (take && req_in.op == CMD_TST_Q) begin
                  state_q <= ST_TEST;
               end
            end
            ST_WAIT: begin
               if (!pending_busy_in) begin
                  state_q <= ST_IDLE; // [RULE15]
               end
            end
            ST_TEST: begin
               if (rom_addr_q == ROM_LAST) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==================================================
   // rom checksum
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rom_addr_q <= ROM_FIRST;
         rom_sum_q <= ZERO_BYTE;
      end else if (take && req_in.op == CMD_TST_Q) begin
         rom_addr_q <= ROM_FIRST;
         rom_sum_q <= ZERO_BYTE;
      end else if (state_q == ST_TEST) begin
         rom_sum_q <= rom_sum_q + rom_data_in; // [RULE14]
         rom_addr_q <= rom_addr_q + 8'h01;
      end
   end

   // ==================================================
   // event and enable registers
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         esr_q <= ZERO_BYTE;
         ese_q <= ZERO_BYTE;
         sre_q <= ZERO_BYTE;
      end else begin
         // new events win over any clear in the same cycle
         if (take && req_in.op == CMD_CLS) begin
            esr_q <= event_set_in; // [RULE1]
         end else if (esr_read) begin
            esr_q <= event_set_in; // [RULE3]
         end else begin
            esr_q <= esr_q | event_set_in;
         end
         if (opc_hit) begin
            esr_q[ESR_OPC_BIT] <= 1'b1; // [RULE4]
         end
         if (take && req_in.op == CMD_ESE) begin
            ese_q <= req_in.arg; // [RULE2]
         end
         if (take && req_in.op == CMD_SRE) begin
            sre_q <= req_in.arg; // [RULE11]
         end
      end
   end

   // ==================================================
   // error queue presence; the queue itself lives outside
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         err_cnt_nz_q <= 1'b0;
         err_clear_out <= 1'b0;
      end else begin
         err_clear_out <= take && req_in.op == CMD_CLS; // [RULE1]
         if (err_push_in) begin
            err_cnt_nz_q <= 1'b1;
         end else if (take && req_in.op == CMD_CLS) begin
            err_cnt_nz_q <= 1'b0; // [RULE1]
         end
      end
   end

   // ==================================================
   // status byte
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         stb_out <= ZERO_BYTE;
      end else begin
         stb_out <= ZERO_BYTE;
         stb_out[STB_ESB_BIT] <= |(esr_q & ese_q); // [RULE16]
         stb_out[STB_EAV_BIT] <= err_cnt_nz_q;
      end
   end

   // ==================================================
   // setup save / recall / reset; status and trace live elsewhere, untouched
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         setup_q <= SETUP_RST;
         setup_load_out <= 1'b0;
         for (int i = 0; i < SLOTS; i++) begin
            slot_q[i] <= SETUP_RST;
         end
      end else begin
         setup_load_out <= 1'b0;
         setup_q <= setup_in;
         if (take && req_in.op == CMD_SAV) begin
            slot_q[slot_idx] <= setup_in; // [RULE8]
         end
         if (take && req_in.op == CMD_RCL) begin
            setup_q <= slot_q[slot_idx]; // [RULE9]
            setup_load_out <= 1'b1;
         end else if (take && req_in.op == CMD_RST) begin
            setup_q <= SETUP_RST; // [RULE10]
            setup_load_out <= 1'b1;
         end
      end
   end

   // ==================================================
   // responses and trigger
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rsp_valid_out <= 1'b0;
         rsp_out <= '0;
         bus_trigger_out <= 1'b0;
      end else begin
         rsp_valid_out <= 1'b0;
         bus_trigger_out <= take && req_in.op == CMD_TRG; // [RULE13]
         if (take) begin
            case (req_in.op)
               CMD_ESE_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_BYTE, ese_q}; // [RULE2]
               end
               CMD_ESR_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_BYTE, esr_q}; // [RULE3]
               end
               CMD_SRE_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_BYTE, sre_q}; // [RULE11]
               end
               CMD_STB_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_BYTE, stb_out}; // [RULE12]
               end
               CMD_IDN_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_ID, ZERO_BYTE}; // [RULE6]
               end
               CMD_OPT_Q: begin
                  rsp_valid_out <= 1'b1;
                  rsp_out <= '{RSP_OPT, {5'h00, scanner_in, mem_opt_in}}; // [RULE7]
               end
               default: begin
               end
            endcase
         end else if (state_q == ST_WAIT && !pending_busy_in && wait_op_q == CMD_OPC_Q) begin
            rsp_valid_out <= 1'b1;
            rsp_out <= '{RSP_BYTE, ASCII_ONE}; // [RULE5]
         end else if (state_q == ST_TEST && rom_addr_q == ROM_LAST) begin
            rsp_valid_out <= 1'b1;
            rsp_out <= '{RSP_TEST, (rom_sum_q + rom_data_in == ROM_SUM_GOOD) ? TST_PASS : TST_FAIL}; // [RULE14]
         end
      end
   end
endmodule // ccs_core

/* bench/ccs_rom_model.sv */
`timescale 1ns/1ps
module ccs_rom_model
   import ccs_pkg::*;
(
   input wire logic [ccs_pkg::ROM_AW-1:0] addr_in,
   input wire logic corrupt_in,
   output logic [ccs_pkg::DATA_W-1:0] data_out
);
   // one bad byte is enough to make the sum nonzero
   assign data_out = (corrupt_in && addr_in == ROM_FIRST) ? 8'h01 : ZERO_BYTE;
endmodule // ccs_rom_model

/* bench/ccs_core_props.sv */
`timescale 1ns/1ps
module ccs_core_props
   import ccs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic req_valid_in,
   input wire ccs_pkg::ccs_req_s req_in,
   input wire logic req_ready_out,
   input wire logic rsp_valid_out,
   input wire ccs_pkg::ccs_rsp_s rsp_out,
   input wire logic err_clear_out,
   input wire logic [1:0] mem_opt_in,
   input wire logic scanner_in,
   input wire logic pending_busy_in,
   input wire logic [ccs_pkg::SETUP_W-1:0] setup_out,
   input wire logic setup_load_out,
   input wire logic bus_trigger_out
);
   logic take;
   assign take = req_valid_in && req_ready_out;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // ====
   // command effects
   a_query_answer: assert property (take && req_in.op inside {CMD_ESE_Q, CMD_ESR_Q, CMD_SRE_Q, CMD_STB_Q}
      |=> rsp_valid_out) else $error("query not answered");
   a_cls_clear: assert property (take && req_in.op == CMD_CLS |=> err_clear_out) else $error("no clear");
   a_opt_code: assert property (take && req_in.op == CMD_OPT_Q
      |=> rsp_out.data == {5'h00, $past(scanner_in), $past(mem_opt_in)}) else $error("bad option code");
   a_wai_stall: assert property (take && req_in.op == CMD_WAI && pending_busy_in
      |=> !req_ready_out) else $error("wait did not stall");
   a_opc_hold: assert property (take && req_in.op == CMD_OPC_Q && pending_busy_in
      |=> !rsp_valid_out) else $error("early completion answer");
   a_rcl_load: assert property (take && req_in.op == CMD_RCL |-> ##[1:2] setup_load_out)
      else $error("recall not applied");
   a_rst_default: assert property (take && req_in.op == CMD_RST
      |-> ##[1:2] (setup_load_out && setup_out == SETUP_RST)) else $error("reset not applied");
   a_trg_pulse: assert property (take && req_in.op == CMD_TRG |=> bus_trigger_out)
      else $error("no bus trigger");
   a_idn_kind: assert property (take && req_in.op == CMD_IDN_Q
      |=> rsp_valid_out && rsp_out.kind == RSP_ID) else $error("identity answer missing");
endmodule // ccs_core_props
bind ccs_core ccs_core_props u_props (.ref_clk_in, .srst_in, .req_valid_in, .req_in, .req_ready_out,
   .rsp_valid_out, .rsp_out, .err_clear_out, .mem_opt_in, .scanner_in, .pending_busy_in, .setup_out,
   .setup_load_out, .bus_trigger_out);

/* bench/test_ccs_core.sv */
`timescale 1ns/1ps
module test_ccs_core;
   import ccs_pkg::*;
   logic ref_clk, srst, req_valid, busy, err_push, scanner, rom_bad, ready, rsp_valid, err_clear, err_avail;
   logic setup_load, trig;
   ccs_req_s req;
   ccs_rsp_s rsp;
   logic [DATA_W-1:0] ev_set, rom_data, stb;
   logic [1:0] mem_opt;
   logic [SETUP_W-1:0] setup_in, setup_o;
   logic [4*ID_W-1:0] idn;
   logic [ROM_AW-1:0] rom_addr;
   int fail_count = 0;
   int checked = 0;
   always #2.5 ref_clk = ~ref_clk;
   ccs_core #(.MAKER_ID(4'h1), .MODEL_ID(4'h2), .SERIAL_ID(4'h3), .FW_REV(4'h4), .SLOTS(8)) DUT (
      .ref_clk_in(ref_clk), .srst_in(srst), .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready),
      .rsp_valid_out(rsp_valid), .rsp_out(rsp), .idn_out(idn), .pending_busy_in(busy), .event_set_in(ev_set),
      .err_push_in(err_push), .err_clear_out(err_clear), .err_avail_out(err_avail), .mem_opt_in(mem_opt),
      .scanner_in(scanner), .rom_addr_out(rom_addr), .rom_data_in(rom_data), .setup_in(setup_in),
      .setup_out(setup_o), .setup_load_out(setup_load), .bus_trigger_out(trig), .stb_out(stb));
   ccs_rom_model u_rom (.addr_in(rom_addr), .corrupt_in(rom_bad), .data_out(rom_data));
   // ====
   // helpers
   task automatic chk(input logic [SETUP_W-1:0] got, input logic [SETUP_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic send(input ccs_cmd_e op, input logic [DATA_W-1:0] arg);
      int n;
      n = 0;
      while (!ready && n < 400) begin
         tick(1);
         n++;
      end
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{op, arg};
      @(posedge ref_clk);
      req_valid <= 1'b0;
      #1;
   endtask
   task automatic got(input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      while (!rsp_valid && n < 400) begin
         tick(1);
         n++;
      end
      chk(16'(rsp_valid), 16'h0001);
      chk(16'(rsp.data), 16'(exp));
   endtask
   // the answer pulse stands for one cycle only, so poll for it every cycle, up to 400 cycles
   task automatic ask(input ccs_cmd_e op, input logic [DATA_W-1:0] exp);
      send(op, ZERO_BYTE);
      got(exp);
   endtask
   task automatic pulse(input logic [DATA_W-1:0] v, input logic e);
      @(posedge ref_clk);
      ev_set <= v;
      err_push <= e;
      @(posedge ref_clk);
      ev_set <= ZERO_BYTE;
      err_push <= 1'b0;
      tick(1);
   endtask
   task automatic set_busy(input logic b);
      @(posedge ref_clk);
      busy <= b;
      #1;
   endtask
   task automatic wait_load(input logic [SETUP_W-1:0] exp);
      int n;
      n = 0;
      while (!setup_load && n < 8) begin
         tick(1);
         n++;
      end
      chk(16'(setup_load), 16'h0001);
      chk(setup_o, exp);
   endtask
   // ====
   // scenarios
   task automatic t_status;
      send(CMD_ESE, 8'h55);
      ask(CMD_ESE_Q, 8'h55);
      ask(CMD_ESE_Q, 8'h55);
      send(CMD_SRE, 8'ha5);
      ask(CMD_SRE_Q, 8'ha5);
      pulse(8'h02, 1'b0);
      chk(16'(stb), 16'h0000);
      pulse(8'h01, 1'b0);
      ask(CMD_STB_Q, 8'h20);
      ask(CMD_ESR_Q, 8'h03);
      ask(CMD_ESR_Q, 8'h00);
      pulse(8'h04, 1'b1);
      chk(16'(stb), 16'h0024);
      chk(16'(err_avail), 16'h0001);
      send(CMD_CLS, ZERO_BYTE);
      tick(2);
      chk(16'(stb), 16'h0000);
      chk(16'(err_avail), 16'h0000);
      ask(CMD_ESR_Q, 8'h00);
   endtask
   task automatic t_sync;
      set_busy(1'b1);
      send(CMD_OPC, ZERO_BYTE);
      tick(5);
      chk(16'(ready), 16'h0000);
      set_busy(1'b0);
      ask(CMD_ESR_Q, 8'h01);
      set_busy(1'b1);
      send(CMD_OPC_Q, ZERO_BYTE);
      tick(4);
      chk(16'(rsp_valid), 16'h0000);
      set_busy(1'b0);
      got(ASCII_ONE);
      set_busy(1'b1);
      send(CMD_WAI, ZERO_BYTE);
      tick(3);
      chk(16'(ready), 16'h0000);
      set_busy(1'b0);
      send(CMD_TRG, ZERO_BYTE);
      chk(16'(trig), 16'h0001);
   endtask
   task automatic t_setup;
      chk(idn, 16'h1234);
      ask(CMD_IDN_Q, ZERO_BYTE);
      chk(16'(rsp.kind), 16'(RSP_ID));
      ask(CMD_OPT_Q, 8'h06);
      chk(16'(rsp.kind), 16'(RSP_OPT));
      send(CMD_SAV, 8'h03);
      @(posedge ref_clk);
      setup_in <= 16'hbeef;
      send(CMD_SAV, 8'h07);
      send(CMD_RCL, 8'h03);
      wait_load(16'h1234);
      send(CMD_RCL, 8'h07);
      wait_load(16'hbeef);
      send(CMD_RST, ZERO_BYTE);
      wait_load(SETUP_RST);
      ask(CMD_ESE_Q, 8'h55);
   endtask
   task automatic t_selftest;
      ask(CMD_TST_Q, TST_PASS);
      chk(16'(rsp.kind), 16'(RSP_TEST));
      @(posedge ref_clk);
      rom_bad <= 1'b1;
      ask(CMD_TST_Q, TST_FAIL);
   endtask
   task automatic print_verdict;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      {ref_clk, req_valid, busy, err_push, rom_bad} = '0;
      {req, ev_set} = '0;
      srst = 1'b1;
      mem_opt = 2'b10;
      scanner = 1'b1;
      setup_in = 16'h1234;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      chk(16'(ready), 16'h0001);
      t_status();
      t_sync();
      t_setup();
      t_selftest();
      print_verdict();
   end
   initial begin
      // whole run is well under a thousand cycles
      #100000;
      fail_count++;
      print_verdict();
   end
endmodule // test_ccs_core
